// ### hdl/mhu_dev_end.sv
// Module end of the serial link: three ports plus the UART engines.
// Assumes link pins are asynchronous to mclk_i and are synchronised here.

module mhu_uart_tx (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] div_i,
  input  wire logic        en_i,
  input  wire logic [7:0]  data_i,
  input  wire logic        valid_i,
  output logic             ready_o,
  output logic             line_o
);
  mhu_pkg::mhu_tx_state_type state_q;
  logic [15:0] cnt_q;
  logic [3:0]  bit_q;
  logic [9:0]  shift_q;

  // Disabling mid-frame aborts the character and returns the line high.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= mhu_pkg::TX_IDLE;
      cnt_q   <= 16'h0000;
      bit_q   <= 4'h0;
      shift_q <= 10'h3ff;
      ready_o <= 1'b0;
      line_o  <= 1'b1;
    end else begin
      unique case (state_q)
        mhu_pkg::TX_IDLE: begin
          line_o  <= 1'b1;
          ready_o <= en_i;
          if (valid_i && ready_o && en_i) begin
            shift_q <= {1'b1, data_i, 1'b0};
            line_o  <= 1'b0;
            ready_o <= 1'b0;
            cnt_q   <= div_i - 16'h0001;
            bit_q   <= 4'h0;
            state_q <= mhu_pkg::TX_SHIFT;
          end
        end
        mhu_pkg::TX_SHIFT: begin
          if (!en_i) begin
            line_o  <= 1'b1;
            state_q <= mhu_pkg::TX_IDLE;
          end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (bit_q == 4'(mhu_pkg::FRAME_BITS - 1)) begin
            line_o  <= 1'b1;
            ready_o <= en_i;
            state_q <= mhu_pkg::TX_IDLE;
          end else begin
            shift_q <= {1'b1, shift_q[9:1]};
            line_o  <= shift_q[1];
            bit_q   <= bit_q + 4'h1;
            cnt_q   <= div_i - 16'h0001;
          end
        end
      endcase
    end
  end
endmodule : mhu_uart_tx

module mhu_uart_rx (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] div_i,
  input  wire logic        en_i,
  input  wire logic        line_i,
  output logic [7:0]       data_o,
  output logic             valid_o,
  output logic             err_o
);
  mhu_pkg::mhu_rx_state_type state_q;
  logic        meta_q;
  logic        sync_q;
  logic [15:0] cnt_q;
  logic [2:0]  bit_q;
  logic [7:0]  shift_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= line_i;
      sync_q <= meta_q;
    end
  end

  // A start pulse shorter than half a bit is treated as noise.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= mhu_pkg::RX_IDLE;
      cnt_q   <= 16'h0000;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      data_o  <= 8'h00;
      valid_o <= 1'b0;
      err_o   <= 1'b0;
    end else begin
      valid_o <= 1'b0;
      err_o   <= 1'b0;
      if (!en_i) begin
        state_q <= mhu_pkg::RX_IDLE;
      end else begin
        unique case (state_q)
          mhu_pkg::RX_IDLE: begin
            if (!sync_q) begin
              cnt_q   <= {1'b0, div_i[15:1]};
              state_q <= mhu_pkg::RX_START;
            end
          end
          mhu_pkg::RX_START: begin
            if (cnt_q != 16'h0000) begin
              cnt_q <= cnt_q - 16'h0001;
            end else if (!sync_q) begin
              cnt_q   <= div_i - 16'h0001;
              bit_q   <= 3'h0;
              state_q <= mhu_pkg::RX_DATA;
            end else begin
              state_q <= mhu_pkg::RX_IDLE;
            end
          end
          mhu_pkg::RX_DATA: begin
            if (cnt_q != 16'h0000) begin
              cnt_q <= cnt_q - 16'h0001;
            end else begin
              shift_q <= {sync_q, shift_q[7:1]};
              cnt_q   <= div_i - 16'h0001;
              bit_q   <= bit_q + 3'h1;
              if (bit_q == 3'(mhu_pkg::DATA_BITS - 1)) begin
                state_q <= mhu_pkg::RX_STOP;
              end
            end
          end
          mhu_pkg::RX_STOP: begin
            if (cnt_q != 16'h0000) begin
              cnt_q <= cnt_q - 16'h0001;
            end else begin
              state_q <= mhu_pkg::RX_IDLE;
              if (sync_q) begin
                data_o  <= shift_q;
                valid_o <= 1'b1;
              end else begin
                err_o <= 1'b1;
              end
            end
          end
        endcase
      end
    end
  end
endmodule : mhu_uart_rx

module mhu_dev_end (
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  mhu_link_if.dev                link,
  input  wire logic [1:0]        aux_rate_sel_i,
  input  wire logic [1:0]        module_ready_i,
  input  wire logic [2:0][7:0]   tx_data_i,
  input  wire logic [2:0]        tx_valid_i,
  output logic      [2:0]        tx_ready_o,
  output logic      [2:0][7:0]   rx_data_o,
  output logic      [2:0]        rx_valid_o,
  output logic      [2:0]        rx_err_o,
  output logic      [1:0]        host_ready_o,
  output logic                   aux_enabled_o,
  output logic                   usb_operating_o
);
  logic [2:0]        en;
  logic [2:0][15:0]  div;
  logic [2:0]        rx_line;
  logic [2:0]        tx_line;
  logic [3:0]        lvl_meta_q;
  logic [3:0]        lvl_sync_q;

  // Aux rate changes take effect at once; change it only while idle.
  assign div[mhu_pkg::PORT_PRI] = mhu_pkg::PRI_DIV;
  assign div[mhu_pkg::PORT_AUX] = mhu_pkg::aux_div(aux_rate_sel_i);
  assign div[mhu_pkg::PORT_DBG] = mhu_pkg::DBG_DIV;
  assign en = {1'b1, aux_enabled_o, 1'b1};
  assign rx_line = {link.debug_rx_line, link.aux_rx_line, link.primary_rx_line};
  assign link.primary_tx_line = tx_line[mhu_pkg::PORT_PRI];
  assign link.aux_tx_line     = tx_line[mhu_pkg::PORT_AUX];
  assign link.debug_tx_line   = tx_line[mhu_pkg::PORT_DBG];

  // Slow level pins: two flops each before use.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      // Reset to the idle levels of the host pins, so no false ready follows reset.
      lvl_meta_q <= 4'h3;
      lvl_sync_q <= 4'h3;
    end else begin
      lvl_meta_q <= {link.usb_supply_present, link.debug_host_ready_in,
                     link.aux_port_enable_n, link.primary_host_ready_n};
      lvl_sync_q <= lvl_meta_q;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      aux_enabled_o               <= 1'b0;
      usb_operating_o             <= 1'b0;
      host_ready_o                <= 2'h0;
      link.primary_module_ready_n <= 1'b1;
      link.debug_module_ready_out <= 1'b0;
    end else begin
      aux_enabled_o               <= !lvl_sync_q[1];
      usb_operating_o             <= lvl_sync_q[3];
      host_ready_o                <= {lvl_sync_q[2], !lvl_sync_q[0]};
      link.primary_module_ready_n <= !module_ready_i[0];
      link.debug_module_ready_out <= module_ready_i[1];
    end
  end

  for (genvar p = 0; p < mhu_pkg::NPORT; p++) begin : g_port
    mhu_uart_tx u_tx (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .div_i   (div[p]),
      .en_i    (en[p]),
      .data_i  (tx_data_i[p]),
      .valid_i (tx_valid_i[p]),
      .ready_o (tx_ready_o[p]),
      .line_o  (tx_line[p])
    );
    mhu_uart_rx u_rx (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .div_i   (div[p]),
      .en_i    (en[p]),
      .line_i  (rx_line[p]),
      .data_o  (rx_data_o[p]),
      .valid_o (rx_valid_o[p]),
      .err_o   (rx_err_o[p])
    );
  end
endmodule : mhu_dev_end

// ### hdl/mhu_pkg.sv
// Shared constants and types for the module-to-host serial ports.
// Assumes one 40 MHz clock on both ends of the link.
package mhu_pkg;
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned PRI_BAUD    = 2_500_000;
  localparam int unsigned DBG_BAUD    = 2_500_000;
  localparam int unsigned AUX_BAUD_0  = 115_200;
  localparam int unsigned AUX_BAUD_1  = 460_800;
  localparam int unsigned AUX_BAUD_2  = 921_600;
  localparam int unsigned AUX_BAUD_3  = 3_000_000;
  // High-speed signalling rate of the USB pair; the pair itself is analogue.
  localparam int unsigned USB_HS_BPS  = 480_000_000;
  localparam int unsigned DIV_W       = 16;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned FRAME_BITS  = 10;
  localparam int unsigned NPORT       = 3;
  localparam int unsigned PORT_PRI    = 0;
  localparam int unsigned PORT_AUX    = 1;
  localparam int unsigned PORT_DBG    = 2;

  // Cycles per bit, rounded to the nearest whole cycle.
  localparam logic [15:0] PRI_DIV = 16'((CLK_HZ + PRI_BAUD / 2) / PRI_BAUD);
  localparam logic [15:0] DBG_DIV = 16'((CLK_HZ + DBG_BAUD / 2) / DBG_BAUD);
  localparam logic [15:0] AUX_DIV_0 = 16'((CLK_HZ + AUX_BAUD_0 / 2) / AUX_BAUD_0);
  localparam logic [15:0] AUX_DIV_1 = 16'((CLK_HZ + AUX_BAUD_1 / 2) / AUX_BAUD_1);
  localparam logic [15:0] AUX_DIV_2 = 16'((CLK_HZ + AUX_BAUD_2 / 2) / AUX_BAUD_2);
  localparam logic [15:0] AUX_DIV_3 = 16'((CLK_HZ + AUX_BAUD_3 / 2) / AUX_BAUD_3);

  // Host register byte offsets.
  localparam logic [4:0] REG_CTRL   = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_TX_PRI = 5'h08;
  localparam logic [4:0] REG_TX_AUX = 5'h0c;
  localparam logic [4:0] REG_TX_DBG = 5'h10;
  localparam logic [4:0] REG_RX_PRI = 5'h14;
  localparam logic [4:0] REG_RX_AUX = 5'h18;
  localparam logic [4:0] REG_RX_DBG = 5'h1c;

  // Control field positions.
  localparam int unsigned CTRL_PRI_RDY = 0;
  localparam int unsigned CTRL_DBG_RDY = 1;
  localparam int unsigned CTRL_AUX_EN  = 2;
  localparam int unsigned CTRL_RATE_LO = 3;
  localparam int unsigned CTRL_USB_PWR = 5;
  localparam int unsigned CTRL_W       = 6;
  localparam logic [5:0]  CTRL_RESET   = 6'h00;

  // Status field positions; a two-bit module ready group, then three-bit groups indexed by port.
  localparam int unsigned STS_MOD_RDY = 0;
  localparam int unsigned STS_RX_FULL = 2;
  localparam int unsigned STS_TX_RDY  = 5;
  localparam int unsigned STS_RX_ERR  = 8;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} mhu_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mhu_rx_state_type;

  function automatic logic [15:0] aux_div(input logic [1:0] sel);
    case (sel)
      2'h0:    aux_div = AUX_DIV_0;
      2'h1:    aux_div = AUX_DIV_1;
      2'h2:    aux_div = AUX_DIV_2;
      default: aux_div = AUX_DIV_3;
    endcase
  endfunction : aux_div
endpackage : mhu_pkg

// ### hdl/mhu_link_if.sv
// Pin-level link between the module end and the host end.
// Assumes the bench resolves nothing: all pins are one-way.
interface mhu_link_if;
  logic primary_rx_line;
  logic primary_tx_line;
  logic primary_host_ready_n;
  logic primary_module_ready_n;
  logic aux_rx_line;
  logic aux_tx_line;
  logic aux_port_enable_n;
  logic debug_rx_line;
  logic debug_tx_line;
  logic debug_host_ready_in;
  logic debug_module_ready_out;
  logic usb_supply_present;

  modport dev (
    input  primary_rx_line, primary_host_ready_n, aux_rx_line, aux_port_enable_n,
    input  debug_rx_line, debug_host_ready_in, usb_supply_present,
    output primary_tx_line, primary_module_ready_n, aux_tx_line,
    output debug_tx_line, debug_module_ready_out
  );
  modport host (
    output primary_rx_line, primary_host_ready_n, aux_rx_line, aux_port_enable_n,
    output debug_rx_line, debug_host_ready_in, usb_supply_present,
    input  primary_tx_line, primary_module_ready_n, aux_tx_line,
    input  debug_tx_line, debug_module_ready_out
  );
endinterface : mhu_link_if

// ### hdl/mhu_host_end.sv
// Host end of the serial link, commanded over an Avalon-MM slave.
// Assumes mhu_uart_tx and mhu_uart_rx from the module end are compiled.
module mhu_host_end (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  mhu_link_if.host         link,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  logic [5:0]       ctrl_q;
  logic [2:0][7:0]  rx_buf_q;
  logic [2:0]       rx_full_q;
  logic [2:0]       rx_err_q;
  logic [1:0]       rdy_meta_q;
  logic [1:0]       rdy_sync_q;
  logic [2:0][15:0] div;
  logic [2:0]       en;
  logic [2:0]       tx_ready;
  logic [2:0]       tx_valid;
  logic [2:0]       tx_line;
  logic [2:0]       rx_line;
  logic [2:0][7:0]  rx_data;
  logic [2:0]       rx_valid;
  logic [2:0]       rx_err;
  logic [2:0]       pop;
  logic             done_wr;
  logic             done_rd;
  logic [31:0]      status;

  assign done_wr = avs_write_i && !avs_waitrequest_o;
  assign done_rd = avs_read_i && !avs_waitrequest_o;
  assign div[mhu_pkg::PORT_PRI] = mhu_pkg::PRI_DIV;
  assign div[mhu_pkg::PORT_AUX] = mhu_pkg::aux_div(ctrl_q[mhu_pkg::CTRL_RATE_LO +: 2]);
  assign div[mhu_pkg::PORT_DBG] = mhu_pkg::DBG_DIV;
  assign en = {1'b1, ctrl_q[mhu_pkg::CTRL_AUX_EN], 1'b1};
  assign tx_valid = {done_wr && avs_address_i == mhu_pkg::REG_TX_DBG,
                     done_wr && avs_address_i == mhu_pkg::REG_TX_AUX,
                     done_wr && avs_address_i == mhu_pkg::REG_TX_PRI};
  assign pop = {done_rd && avs_address_i == mhu_pkg::REG_RX_DBG,
                done_rd && avs_address_i == mhu_pkg::REG_RX_AUX,
                done_rd && avs_address_i == mhu_pkg::REG_RX_PRI};
  assign rx_line = {link.debug_tx_line, link.aux_tx_line, link.primary_tx_line};
  assign link.primary_rx_line = tx_line[mhu_pkg::PORT_PRI];
  assign link.aux_rx_line     = tx_line[mhu_pkg::PORT_AUX];
  assign link.debug_rx_line   = tx_line[mhu_pkg::PORT_DBG];
  assign status = 32'({rx_err_q, tx_ready, rx_full_q, rdy_sync_q});

  // Bus slave: one wait cycle, then the access completes.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        unique case (avs_address_i)
          mhu_pkg::REG_CTRL:   avs_readdata_o <= 32'(ctrl_q);
          mhu_pkg::REG_STATUS: avs_readdata_o <= status;
          mhu_pkg::REG_RX_PRI: avs_readdata_o <= 32'(rx_buf_q[mhu_pkg::PORT_PRI]);
          mhu_pkg::REG_RX_AUX: avs_readdata_o <= 32'(rx_buf_q[mhu_pkg::PORT_AUX]);
          mhu_pkg::REG_RX_DBG: avs_readdata_o <= 32'(rx_buf_q[mhu_pkg::PORT_DBG]);
          default:             avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= mhu_pkg::CTRL_RESET;
    end else if (done_wr && avs_address_i == mhu_pkg::REG_CTRL) begin
      ctrl_q <= avs_writedata_i[mhu_pkg::CTRL_W-1:0];
    end
  end

  // Pins come from dedicated flops; the enable idles high as an open pin would.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      link.primary_host_ready_n <= 1'b1;
      link.debug_host_ready_in  <= 1'b0;
      link.aux_port_enable_n    <= 1'b1;
      link.usb_supply_present   <= 1'b0;
    end else begin
      link.primary_host_ready_n <= !ctrl_q[mhu_pkg::CTRL_PRI_RDY];
      link.debug_host_ready_in  <= ctrl_q[mhu_pkg::CTRL_DBG_RDY];
      link.aux_port_enable_n    <= !ctrl_q[mhu_pkg::CTRL_AUX_EN];
      link.usb_supply_present   <= ctrl_q[mhu_pkg::CTRL_USB_PWR];
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_meta_q <= 2'h0;
      rdy_sync_q <= 2'h0;
    end else begin
      rdy_meta_q <= {link.debug_module_ready_out, !link.primary_module_ready_n};
      rdy_sync_q <= rdy_meta_q;
    end
  end

  // A new character beats a pop in the same cycle; an unread one is overwritten.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_buf_q  <= '0;
      rx_full_q <= 3'h0;
      rx_err_q  <= 3'h0;
    end else begin
      for (int p = 0; p < mhu_pkg::NPORT; p++) begin
        if (rx_valid[p]) begin
          rx_buf_q[p]  <= rx_data[p];
          rx_full_q[p] <= 1'b1;
        end else if (pop[p]) begin
          rx_full_q[p] <= 1'b0;
        end
        if (rx_err[p]) begin
          rx_err_q[p] <= 1'b1;
        end else if (done_wr && avs_address_i == mhu_pkg::REG_STATUS && avs_writedata_i[mhu_pkg::STS_RX_ERR + p]) begin
          rx_err_q[p] <= 1'b0;
        end
      end
    end
  end

  for (genvar p = 0; p < mhu_pkg::NPORT; p++) begin : g_port
    mhu_uart_tx u_tx (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .div_i   (div[p]),
      .en_i    (en[p]),
      .data_i  (avs_writedata_i[7:0]),
      .valid_i (tx_valid[p]),
      .ready_o (tx_ready[p]),
      .line_o  (tx_line[p])
    );
    mhu_uart_rx u_rx (
      .clk_i   (mclk_i),
      .rst_i   (rst_i),
      .div_i   (div[p]),
      .en_i    (en[p]),
      .line_i  (rx_line[p]),
      .data_o  (rx_data[p]),
      .valid_o (rx_valid[p]),
      .err_o   (rx_err[p])
    );
  end
endmodule : mhu_host_end

// ### sim/mhu_link_assertions.sv
// Concurrent checks on the serial link pins joining the two ends.
// Assumes one clock shared by both ends; sees only the link signals.
module mhu_link_assertions (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic primary_rx_line,
  input wire logic primary_tx_line,
  input wire logic primary_host_ready_n,
  input wire logic primary_module_ready_n,
  input wire logic aux_rx_line,
  input wire logic aux_tx_line,
  input wire logic aux_port_enable_n,
  input wire logic debug_rx_line,
  input wire logic debug_tx_line,
  input wire logic debug_host_ready_in,
  input wire logic debug_module_ready_out,
  input wire logic usb_supply_present
);
  logic [5:0]       lv;
  logic [5:0][15:0] run_q;

  assign lv = {aux_rx_line, aux_tx_line, debug_rx_line, debug_tx_line, primary_rx_line, primary_tx_line};

  // Every low stretch inside an 8N1 frame is a whole number of bit times.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= '0;
    end else begin
      for (int i = 0; i < 6; i++) begin
        run_q[i] <= lv[i] ? 16'h0000 : run_q[i] + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_fixed(int i);
    $rose(lv[i]) |-> run_q[i][3:0] == 4'h0 && run_q[i] inside {[16'h0010:16'h0090]};
  endproperty
  // An aborted frame may be cut short, so only enabled stretches are judged.
  property p_aux(int i);
    $rose(lv[i]) && !aux_port_enable_n |-> run_q[i] % 13 == 0 || run_q[i] % 43 == 0
      || run_q[i] % 87 == 0 || run_q[i] % 347 == 0;
  endproperty

  chk_pri_tx_rate: assert property (p_fixed(0)) else $error("primary tx bit time wrong");
  chk_pri_rx_rate: assert property (p_fixed(1)) else $error("primary rx bit time wrong");
  chk_dbg_tx_rate: assert property (p_fixed(2)) else $error("debug tx bit time wrong");
  chk_dbg_rx_rate: assert property (p_fixed(3)) else $error("debug rx bit time wrong");
  chk_aux_tx_rate: assert property (p_aux(4)) else $error("aux tx bit time wrong");
  chk_aux_rx_rate: assert property (p_aux(5)) else $error("aux rx bit time wrong");
  chk_aux_off_tx: assert property (aux_port_enable_n [*8] |-> aux_tx_line)
    else $error("aux tx active while disabled");
  chk_aux_off_rx: assert property (aux_port_enable_n [*8] |-> aux_rx_line)
    else $error("aux rx active while disabled");
  chk_idle_after_rst: assert property ($fell(rst_i) |-> &lv) else $error("line not idle high");

  cover property ($rose(primary_tx_line));
  cover property ($rose(aux_tx_line) && !aux_port_enable_n);
  cover property ($rose(debug_rx_line));
endmodule : mhu_link_assertions

// ### sim/module_host_uart_ports_tb.sv
// Self-checking bench: host end and module end joined by the link interface.
// Assumes the host end is driven over Avalon-MM and the module end by its user ports.
module module_host_uart_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic            mclk_i, rst_i, aux_enabled_o, usb_operating_o;
  logic [1:0]      aux_rate_sel_i, module_ready_i, host_ready_o;
  logic [2:0][7:0] tx_data_i, rx_data_o;
  logic [2:0]      tx_valid_i, tx_ready_o, rx_valid_o, rx_err_o;
  logic [4:0]      avs_address_i;
  logic            avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [31:0]     avs_writedata_i, avs_readdata_o, rd;
  logic [7:0]      b;
  int              miscompares, tests_run, n;
  int unsigned     bauds[4] = '{mhu_pkg::AUX_BAUD_0, mhu_pkg::AUX_BAUD_1, mhu_pkg::AUX_BAUD_2, mhu_pkg::AUX_BAUD_3};

  mhu_link_if link ();
  mhu_dev_end i_mhu_dev_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .aux_rate_sel_i(aux_rate_sel_i),
    .module_ready_i(module_ready_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_err_o(rx_err_o), .host_ready_o(host_ready_o),
    .aux_enabled_o(aux_enabled_o), .usb_operating_o(usb_operating_o));
  mhu_host_end i_mhu_host_end (.mclk_i(mclk_i), .rst_i(rst_i), .link(link), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o));
  mhu_link_assertions i_mhu_link_assertions (.mclk_i(mclk_i), .rst_i(rst_i),
    .primary_rx_line(link.primary_rx_line), .primary_tx_line(link.primary_tx_line),
    .primary_host_ready_n(link.primary_host_ready_n), .primary_module_ready_n(link.primary_module_ready_n),
    .aux_rx_line(link.aux_rx_line), .aux_tx_line(link.aux_tx_line), .aux_port_enable_n(link.aux_port_enable_n),
    .debug_rx_line(link.debug_rx_line), .debug_tx_line(link.debug_tx_line),
    .debug_host_ready_in(link.debug_host_ready_in), .debug_module_ready_out(link.debug_module_ready_out),
    .usb_supply_present(link.usb_supply_present));

  function automatic int cyc(input int unsigned baud);
    return (mhu_pkg::CLK_HZ + baud / 2) / baud;
  endfunction : cyc

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      k++;
    end while (avs_waitrequest_o !== 1'b0 && k < 64);
    if (k >= 64) begin
      miscompares++;
      $display("MISMATCH %0t bus answer timed out", $time);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus

  task automatic host_send(input int p, input logic [7:0] v);
    int k;
    k = 0;
    bus(1'b1, mhu_pkg::REG_TX_PRI + 5'(4 * p), 32'(v));
    do begin
      @(posedge mclk_i);
      k++;
    end while (rx_valid_o[p] !== 1'b1 && k < 5000);
    check(32'(rx_valid_o[p] === 1'b1), 32'h0000_0001, "module rx valid");
    check(32'(rx_data_o[p]), 32'(v), "module rx byte");
  endtask : host_send

  task automatic dev_send(input int p, input int div, input logic [7:0] v);
    logic [9:0] f;
    int         k;
    k = 0;
    @(posedge mclk_i);
    tx_data_i[p] <= v;
    tx_valid_i[p] <= 1'b1;
    do begin
      @(posedge mclk_i);
      k++;
    end while (tx_ready_o[p] !== 1'b1 && k < 500);
    tx_valid_i[p] <= 1'b0;
    repeat (div / 2) @(posedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      f[i] = p == 0 ? link.primary_tx_line : p == 1 ? link.aux_tx_line : link.debug_tx_line;
      repeat (div) @(posedge mclk_i);
    end
    check(32'(f), 32'({1'b1, v, 1'b0}), "wire frame");
    k = 0;
    do begin
      bus(1'b0, mhu_pkg::REG_STATUS, 32'h0000_0000);
      k++;
    end while (rd[mhu_pkg::STS_RX_FULL + p] !== 1'b1 && k < 2000);
    check(32'(rd[mhu_pkg::STS_RX_FULL + p]), 32'h0000_0001, "host rx full");
    bus(1'b0, mhu_pkg::REG_RX_PRI + 5'(4 * p), 32'h0000_0000);
    check(32'(rd[7:0]), 32'(v), "host rx byte");
  endtask : dev_send

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // A full run takes some 17000 cycles, mostly in the aux rate tests; a hang ends here.
  initial begin
    #(25 * 60000);
    miscompares++;
    complete_run();
  end

  initial begin
    rst_i = 1'b1;
    {aux_rate_sel_i, module_ready_i, tx_data_i, tx_valid_i} = '0;
    {avs_address_i, avs_read_i, avs_write_i, avs_writedata_i} = '0;
    void'($urandom(32'hec38c961));
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b0;
    bus(1'b1, 5'h01, 32'hffff_ffff);
    bus(1'b0, mhu_pkg::REG_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0000, "ctrl after reset");
    bus(1'b0, 5'h01, 32'h0000_0000);
    check(rd, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, mhu_pkg::REG_CTRL, 32'((v / 4) * 32 + v % 4));
      module_ready_i <= 2'(v);
      repeat (8) @(posedge mclk_i);
      check(32'(host_ready_o), 32'(v % 4), "host ready");
      check(32'({link.debug_module_ready_out, ~link.primary_module_ready_n}), 32'(v % 4), "module pins");
      bus(1'b0, mhu_pkg::REG_STATUS, 32'h0000_0000);
      check(32'(rd[1:0]), 32'(v % 4), "module ready status");
      check(32'(rd[10:2]), 32'h0000_0028, "status with aux off");
      check(32'(usb_operating_o), 32'(v / 4), "usb operating");
    end
    $display("test ready and usb done");
    for (int p = 0; p < 3; p += 2) begin
      for (int j = 0; j < 4; j++) begin
        b = j == 0 ? 8'h00 : j == 1 ? 8'hff : 8'($urandom);
        host_send(p, b);
        dev_send(p, cyc(p == 0 ? mhu_pkg::PRI_BAUD : mhu_pkg::DBG_BAUD), ~b);
      end
    end
    $display("test primary and debug done");
    for (int r = 0; r < 4; r++) begin
      aux_rate_sel_i <= 2'(r);
      bus(1'b1, mhu_pkg::REG_CTRL, 32'(4 + r * 8));
      repeat (8) @(posedge mclk_i);
      check(32'(aux_enabled_o), 32'h0000_0001, "aux enabled");
      b = 8'($urandom);
      host_send(1, b);
      dev_send(1, cyc(bauds[r]), b ^ 8'h5a);
    end
    $display("test aux rates done");
    bus(1'b1, mhu_pkg::REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge mclk_i);
    check(32'(aux_enabled_o), 32'h0000_0000, "aux disabled");
    check(32'(tx_ready_o[1]), 32'h0000_0000, "aux tx ready off");
    bus(1'b1, mhu_pkg::REG_TX_AUX, 32'h0000_00a5);
    tx_data_i[1]  <= 8'h3c;
    tx_valid_i[1] <= 1'b1;
    n = 0;
    repeat (4000) begin
      @(posedge mclk_i);
      n += int'(rx_valid_o[1] === 1'b1);
      n += int'(link.aux_tx_line !== 1'b1) + int'(tx_ready_o[1] !== 1'b0) + int'(rx_err_o !== 3'h0);
    end
    tx_valid_i[1] <= 1'b0;
    check(32'(n), 32'h0000_0000, "aux rx while disabled");
    bus(1'b0, mhu_pkg::REG_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_00a3, "status after aux off");
    $display("test aux disabled done");
    complete_run();
  end
endmodule : module_host_uart_ports_tb
